// ---- triple_comparator_map.vh ----
// Register map, field positions, reset values and codes of the triple comparator block
`ifndef TRIPLE_COMPARATOR_MAP_VH
`define TRIPLE_COMPARATOR_MAP_VH
// Byte offsets
`define CMP_CTRL0_OFS 12'h000
`define CMP_CTRL1_OFS 12'h004
`define CMP_CTRL2_OFS 12'h008
`define CMP_STAT_OFS 12'h00c
`define LADDER_CTRL_OFS 12'h010
`define IRQ_STAT_OFS 12'h014
`define IRQ_MASK_OFS 12'h018
// Comparator control fields
`define CC_ON_BIT 15
`define CC_PIN_BIT 14
`define CC_INV_BIT 13
`define CC_EVT_BIT 9
`define CC_RES_BIT 8
`define CC_EDGE_HI 7
`define CC_EDGE_LO 6
`define CC_REF_BIT 4
`define CC_SEL_HI 1
`define CC_SEL_LO 0
`define CC_WMASK 16'he0d3
// Summary status fields
`define CS_IDLE_BIT 15
`define CS_EVT_LO 8
`define CS_RES_LO 0
// Ladder control fields
`define LC_ON_BIT 7
`define LC_PIN_BIT 6
`define LC_RANGE_BIT 5
`define LC_SUPPLY_BIT 4
`define LC_LEVEL_HI 3
`define LC_LEVEL_LO 0
`define LC_WMASK 16'h00ff
// Reset values
`define CC_RESET 16'h0000
`define CS_RESET 16'h0000
`define LC_RESET 16'h0000
// Edge select codes
`define EDGE_NONE 2'b00
`define EDGE_RISE 2'b01
`define EDGE_FALL 2'b10
`define EDGE_ANY 2'b11
// Inverting input select codes
`define SEL_PIN_B 2'b00
`define SEL_PIN_C 2'b01
`define SEL_PIN_D 2'b10
`define SEL_HALF_BG 2'b11
`endif

// ---- comparator_channel.v ----
// One comparator channel: input mux, enable, invert, edge detect and event latch
`timescale 1ns/10ps
module comparator_channel (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Configuration
  input wire comparator_on,
  input wire result_invert,
  input wire [1:0] event_edge_select,
  input wire [1:0] inv_input_select,
  input wire noninv_ref_select,
  // Analog front end results, one per inverting input choice: B, C, D and half band gap
  input wire [3:0] raw_vs_sel,
  // Event clear
  input wire event_clear,
  // Results
  output wire raw_result,
  output reg compare_result_r,
  output reg event_latched_r,
  output reg event_pulse_r
);
`include "triple_comparator_map.vh"
  // raw_vs_sel carries the analog decision for each of B, C, D, half band gap
  reg sel_raw;
  reg sync1_r;
  reg sync2_r;
  wire trig;
  always @* begin
    case (inv_input_select)
      `SEL_PIN_B: sel_raw = raw_vs_sel[0];
      `SEL_PIN_C: sel_raw = raw_vs_sel[1];
      `SEL_PIN_D: sel_raw = raw_vs_sel[2];
      default: sel_raw = raw_vs_sel[3];
    endcase
  end
  // Pin sees the unsynchronised decision, gated and inverted only
  assign raw_result = comparator_on & (sel_raw ^ result_invert);
  // Two-stage synchroniser, the analog decision is asynchronous
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= raw_result;
      sync2_r <= sync1_r;
    end
  end
  assign trig = comparator_on &&
    ((event_edge_select == `EDGE_RISE && sync2_r && !compare_result_r) ||
     (event_edge_select == `EDGE_FALL && !sync2_r && compare_result_r) ||
     (event_edge_select == `EDGE_ANY && sync2_r != compare_result_r));
  // Event latch blocks further triggers until cleared; a set wins over a clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_result_r <= 1'b0;
      event_latched_r <= 1'b0;
      event_pulse_r <= 1'b0;
    end else if (ce) begin
      compare_result_r <= sync2_r;
      event_pulse_r <= trig & ~event_latched_r;
      if (trig & ~event_latched_r)
        event_latched_r <= 1'b1;
      else if (event_clear)
        event_latched_r <= 1'b0;
    end
  end
endmodule // comparator_channel

// ---- triple_comparator_control.v ----
// Top of the triple comparator block with its reference ladder control and AHB-Lite slave
//
// Functional notes
// - Three independent channels, each a one-bit result
// - Each channel has its own control register
// - Inputs from four pins or a reference
// - Pin drive enable routes raw result out
// - Inverting select: 11 bg/2, 10 D, 01 C, 00 B
// - Shared status shows results and events
// - Status result bits copy control bit 8
// - Ladder has two ranges of sixteen levels
// - Ladder range at ladder control bit 5
// - Four-bit ladder level code
// - Ladder supply select at bit 4
`timescale 1ns/10ps
module triple_comparator_control (
  // Clock, reset and clock enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Analog decisions per channel: bits B, C, D, half band gap for each of three channels
  input wire [11:0] analog_decision,
  // Analog steering to the front end
  output reg [2:0] noninv_ref_select,
  output reg [5:0] inv_input_select,
  output reg [2:0] comparator_on,
  // Result pins and their drive enables
  output reg [2:0] result_pin,
  output reg [2:0] result_pin_oe,
  // Reference ladder steering
  output reg ladder_on,
  output reg ladder_pin_drive,
  output reg ladder_range_select,
  output reg ladder_supply_select,
  output reg [3:0] ladder_level_code,
  output reg idle_halt,
  // Interrupt
  output reg irq
);
`include "triple_comparator_map.vh"
  localparam NCH = 3;

  reg [15:0] ctrl_r [0:NCH-1];
  reg [15:0] ladder_r;
  reg idle_halt_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg wr_pend_r;
  reg [11:0] addr_r;
  wire [2:0] raw_res;
  wire [2:0] res;
  wire [2:0] evt;
  wire [2:0] evt_pulse;
  wire [2:0] evt_clear;
  wire take;
  wire rd_take;
  wire rd_stat;
  reg [31:0] rd_val;
  integer i;

  // Word-aligned offset compare, used by both read and write decode
  function sel_at;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel_at = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // Control word as software reads it, with live result and event
  function [15:0] ctrl_view;
    input [15:0] c;
    input e;
    input r;
    begin
      ctrl_view = c & `CC_WMASK;
      ctrl_view[`CC_EVT_BIT] = e;
      ctrl_view[`CC_RES_BIT] = r;
    end
  endfunction

  assign take = hsel & hready & htrans[1];
  assign rd_take = take & ~hwrite;
  assign rd_stat = rd_take & sel_at(haddr, `IRQ_STAT_OFS);

  // Channels; software clears an event by writing zero to its bit
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      // Channel word offset sized to the bus address on purpose
      localparam [11:0] CH_OFS = 4 * g;
      assign evt_clear[g] = wr_pend_r && sel_at(addr_r, CH_OFS) && !hwdata[`CC_EVT_BIT];
      comparator_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .comparator_on(ctrl_r[g][`CC_ON_BIT]),
        .result_invert(ctrl_r[g][`CC_INV_BIT]),
        .event_edge_select(ctrl_r[g][`CC_EDGE_HI:`CC_EDGE_LO]),
        .inv_input_select(ctrl_r[g][`CC_SEL_HI:`CC_SEL_LO]),
        .noninv_ref_select(ctrl_r[g][`CC_REF_BIT]),
        .raw_vs_sel(analog_decision[4*g+3:4*g]),
        .event_clear(evt_clear[g]),
        .raw_result(raw_res[g]),
        .compare_result_r(res[g]),
        .event_latched_r(evt[g]),
        .event_pulse_r(evt_pulse[g])
      );
    end
  endgenerate

  // Register writes land in the data phase; no wait states needed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < NCH; i = i + 1)
        ctrl_r[i] <= `CC_RESET;
      ladder_r <= `LC_RESET;
      idle_halt_r <= 1'b0;
      irq_mask_r <= 3'h0;
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (ce) begin
      wr_pend_r <= take & hwrite;
      if (take)
        addr_r <= haddr;
      if (wr_pend_r) begin
        for (i = 0; i < NCH; i = i + 1)
          if (sel_at(addr_r, 12'h004 * i[11:0]))
            ctrl_r[i] <= hwdata[15:0] & `CC_WMASK;
        if (sel_at(addr_r, `LADDER_CTRL_OFS))
          ladder_r <= hwdata[15:0] & `LC_WMASK;
        if (sel_at(addr_r, `CMP_STAT_OFS))
          idle_halt_r <= hwdata[`CS_IDLE_BIT];
        if (sel_at(addr_r, `IRQ_MASK_OFS))
          irq_mask_r <= hwdata[2:0];
      end
    end
  end

  // Interrupt status: sticky per new event, cleared by a read; a set in the same cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq_stat_r <= 3'h0;
    else if (ce)
      irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | evt_pulse;
  end

  // Read mux, unmapped addresses read zero
  always @* begin
    rd_val = 32'h0000_0000;
    if (sel_at(haddr, `CMP_CTRL0_OFS))
      rd_val[15:0] = ctrl_view(ctrl_r[0], evt[0], res[0]);
    else if (sel_at(haddr, `CMP_CTRL1_OFS))
      rd_val[15:0] = ctrl_view(ctrl_r[1], evt[1], res[1]);
    else if (sel_at(haddr, `CMP_CTRL2_OFS))
      rd_val[15:0] = ctrl_view(ctrl_r[2], evt[2], res[2]);
    else if (sel_at(haddr, `CMP_STAT_OFS))
      rd_val[15:0] = {idle_halt_r, 4'h0, evt, 5'h00, res};
    else if (sel_at(haddr, `LADDER_CTRL_OFS))
      rd_val[15:0] = ladder_r;
    else if (sel_at(haddr, `IRQ_STAT_OFS))
      rd_val[2:0] = irq_stat_r;
    else if (sel_at(haddr, `IRQ_MASK_OFS))
      rd_val[2:0] = irq_mask_r;
  end

  // Registered outputs; pin path adds one flop of delay, traded for a clean top boundary
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      noninv_ref_select <= 3'h0;
      inv_input_select <= 6'h00;
      comparator_on <= 3'h0;
      result_pin <= 3'h0;
      result_pin_oe <= 3'h0;
      ladder_on <= 1'b0;
      ladder_pin_drive <= 1'b0;
      ladder_range_select <= 1'b0;
      ladder_supply_select <= 1'b0;
      ladder_level_code <= 4'h0;
      idle_halt <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_take)
        hrdata <= rd_val;
      for (i = 0; i < NCH; i = i + 1) begin
        noninv_ref_select[i] <= ctrl_r[i][`CC_REF_BIT];
        inv_input_select[2*i+1 -: 2] <= ctrl_r[i][`CC_SEL_HI:`CC_SEL_LO];
        comparator_on[i] <= ctrl_r[i][`CC_ON_BIT];
        result_pin_oe[i] <= ctrl_r[i][`CC_PIN_BIT];
        result_pin[i] <= ctrl_r[i][`CC_PIN_BIT] & raw_res[i];
      end
      ladder_on <= ladder_r[`LC_ON_BIT];
      ladder_pin_drive <= ladder_r[`LC_PIN_BIT];
      ladder_range_select <= ladder_r[`LC_RANGE_BIT];
      ladder_supply_select <= ladder_r[`LC_SUPPLY_BIT];
      ladder_level_code <= ladder_r[`LC_LEVEL_HI:`LC_LEVEL_LO];
      idle_halt <= idle_halt_r;
      irq <= |(((rd_stat ? 3'h0 : irq_stat_r) | evt_pulse) & irq_mask_r);
    end
  end
endmodule // triple_comparator_control

// ---- tcc_sva.sv ----
// Checker for the triple comparator block ports
`timescale 1ns/10ps
`include "triple_comparator_map.vh"
module tcc_sva (
  // Clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  // Steering and pins
  input wire [2:0] noninv_ref_select,
  input wire [5:0] inv_input_select,
  input wire [2:0] comparator_on,
  input wire [2:0] result_pin,
  input wire [2:0] result_pin_oe,
  input wire ladder_range_select,
  input wire ladder_supply_select,
  input wire [3:0] ladder_level_code,
  input wire irq
);
  reg ap_r, wv_r;
  reg [11:0] aa_r, wa_r;
  reg [31:0] wd_r, d_r;
  reg [1:0] g_r;
  // Follow each write into its data phase, then hold its word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= 1'b0; wv_r <= 1'b0; aa_r <= 12'h0; wa_r <= 12'h0;
      wd_r <= 32'h0; d_r <= 32'h0; g_r <= 2'h0;
    end else begin
      ap_r <= hsel & hready & htrans[1] & hwrite & ce;
      aa_r <= haddr;
      wv_r <= ap_r & ce;
      wa_r <= aa_r;
      wd_r <= hwdata;
      if (wv_r) begin
        d_r <= wd_r;
        g_r <= wa_r[3:2];
      end
    end
  end
  wire lad = wv_r && wa_r == `LADDER_CTRL_OFS;
  wire cc = wv_r && wa_r < `CMP_STAT_OFS;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ladder_range: assert property (lad |=> ladder_range_select == d_r[5]) else $error("range");
  a_ladder_supply: assert property (lad |=> ladder_supply_select == d_r[4]) else $error("supply");
  a_ladder_level: assert property (lad |=> ladder_level_code == d_r[3:0]) else $error("level");
  a_ctrl_select: assert property (cc |=> inv_input_select[2*g_r+:2] == d_r[1:0]) else $error("sel");
  a_ctrl_enable: assert property (cc |=> comparator_on[g_r] == d_r[15]) else $error("on");
  a_ctrl_ref: assert property (cc |=> noninv_ref_select[g_r] == d_r[4]) else $error("ref");
  a_pin_drive: assert property (cc |=> result_pin_oe[g_r] == d_r[14]) else $error("oe");
  a_pin_off_low: assert property ((result_pin & ~result_pin_oe) == 3'h0) else $error("pin");
  a_pin_needs_on: assert property ((result_pin & ~comparator_on) == 3'h0) else $error("off");
  // Main scenarios reached
  cover property (lad);
  cover property ($rose(irq));
  cover property ($rose(result_pin[0]));
endmodule // tcc_sva
bind triple_comparator_control tcc_sva tcc_sva_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .noninv_ref_select(noninv_ref_select), .inv_input_select(inv_input_select),
  .comparator_on(comparator_on), .result_pin(result_pin), .result_pin_oe(result_pin_oe),
  .ladder_range_select(ladder_range_select), .ladder_supply_select(ladder_supply_select),
  .ladder_level_code(ladder_level_code), .irq(irq));

// ---- analog_front_model.sv ----
// Analog front end model for the comparator inputs
`timescale 1ns/10ps
module analog_front_model (
  // Commanded levels
  input wire [11:0] level,
  // Decisions to the block
  output wire [11:0] analog_decision
);
  // Asynchronous decisions, off the clock edge on purpose
  assign #2 analog_decision = level;
endmodule // analog_front_model

// ---- triple_comparator_control_bench.sv ----
// Self-checking bench for the triple comparator block
`timescale 1ns/10ps
`include "triple_comparator_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module triple_comparator_control_bench;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg [1:0] htrans = 0;
  reg [11:0] haddr = 0, lvl = 0;
  reg [31:0] hwdata = 0, q;
  wire [31:0] hrdata;
  wire [11:0] ad;
  wire [5:0] iis;
  wire [3:0] llc;
  wire [2:0] nrs, con, rp, rpoe;
  wire hreadyout, hresp, lo, lpd, lrs, lss, ih, irq;
  int miscompares = 0, check_count = 0;
  always #2.5 hclk = ~hclk;
  analog_front_model analog_front_model_inst (.level(lvl), .analog_decision(ad));
  triple_comparator_control triple_comparator_control_inst (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_decision(ad), .noninv_ref_select(nrs), .inv_input_select(iis), .comparator_on(con),
    .result_pin(rp), .result_pin_oe(rpoe), .ladder_on(lo), .ladder_pin_drive(lpd),
    .ladder_range_select(lrs), .ladder_supply_select(lss), .ladder_level_code(llc),
    .idle_halt(ih), .irq(irq));
  task tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin miscompares++; tally_and_finish; end
  endtask
  // One single word transfer; one idle edge first so no signal is set twice at one edge
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    rdy;
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task settle; repeat (8) @(posedge hclk); endtask
  task t_reset;
    for (int a = 0; a < 32; a += 4) begin bus(0, a[11:0], 0); `CHK(q, 32'h0)  end
    `CHK(hresp, 1'b0)
  endtask
  task t_ladder;
    bus(1, `LADDER_CTRL_OFS, 32'hffffffff); bus(0, `LADDER_CTRL_OFS, 0); `CHK(q, 32'hff)
    bus(1, `LADDER_CTRL_OFS, 32'h2a); settle; `CHK({lo, lpd, lrs, lss, llc}, 8'h2a)
  endtask
  task t_select;
    for (int s = 0; s < 4; s++) begin
      lvl <= 12'h1 << s; bus(1, `CMP_CTRL0_OFS, 32'hc000 | s); settle;
      `CHK(rp[0], 1'b1)
      bus(0, `CMP_CTRL0_OFS, 0); `CHK(q[8], 1'b1)
      bus(0, `CMP_STAT_OFS, 0); `CHK(q[0], 1'b1)
      bus(1, `CMP_CTRL0_OFS, 32'he000 | s); settle; `CHK(rp[0], 1'b0)
    end
  endtask
  task t_events;
    bus(1, `IRQ_MASK_OFS, 32'h2);
    for (int e = 0; e < 4; e++) begin
      lvl <= 0; bus(1, `CMP_CTRL1_OFS, 32'h8000 | e << 6); settle; bus(0, `IRQ_STAT_OFS, 0);
      lvl <= 12'h010; settle; `CHK(irq, e[0])
      bus(0, `CMP_CTRL1_OFS, 0); `CHK(q[9], e[0])
      bus(0, `CMP_STAT_OFS, 0); `CHK(q[9], e[0])
      bus(0, `IRQ_STAT_OFS, 0); `CHK(q[1], e[0])
      bus(0, `IRQ_STAT_OFS, 0); `CHK(q[1], 1'b0)
      lvl <= 0; settle; bus(0, `IRQ_STAT_OFS, 0); `CHK(q[1], e == 2)
    end
    bus(1, `CMP_CTRL1_OFS, 32'h80c0); bus(0, `CMP_CTRL1_OFS, 0); `CHK(q[9], 1'b0)
    bus(1, `IRQ_MASK_OFS, 0); lvl <= 12'h010; settle; `CHK(irq, 1'b0)
    bus(0, `IRQ_STAT_OFS, 0); `CHK(q[1], 1'b1)
  endtask
  task t_off;
    lvl <= 12'h100; bus(1, `CMP_CTRL2_OFS, 32'h40c0); settle; `CHK(rp[2], 1'b0)
    bus(0, `CMP_STAT_OFS, 0); `CHK(q[10], 1'b0)
    bus(1, `CMP_STAT_OFS, 32'h8000); settle; `CHK(ih, 1'b1)
    bus(0, `CMP_STAT_OFS, 0); `CHK(q[15], 1'b1)
  endtask
  // Reset for eight cycles, then each scenario in turn
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    t_reset; t_ladder; t_select; t_events; t_off;
    tally_and_finish;
  end
endmodule // triple_comparator_control_bench
